// File: src/vtp_params.svh
`ifndef VTP_PARAMS_SVH
`define VTP_PARAMS_SVH

// Register offsets on the serial control bus
`define VTP_FIXED_PATTERN_CONTROL_OFS 8'h64
`define VTP_PATTERN_CONFIG_OFS 8'h65
`define VTP_CUSTOM_RED_OFS 8'h66
`define VTP_CUSTOM_GREEN_OFS 8'h67
`define VTP_CUSTOM_BLUE_OFS 8'h68
`define VTP_STATUS_OFS 8'h69

// Field positions in the pattern control register
`define VTP_CHOICE_MSB 7
`define VTP_CHOICE_LSB 4
`define VTP_COMPLIANCE_BIT 3
`define VTP_BARS_BIT 2
`define VTP_ENABLE_BIT 0

// Field positions in the pattern configuration register
`define VTP_INVERT_BIT 1

// Field positions in the status register
`define VTP_STAT_ACTIVE_BIT 0
`define VTP_STAT_CODE_MSB 7
`define VTP_STAT_CODE_LSB 4

// Reset values
`define VTP_CHOICE_RST 4'h1
`define VTP_CUSTOM_RST 8'h00

// Selection code boundaries
`define VTP_CODE_SOLID_LO 4'h1
`define VTP_CODE_SOLID_HI 4'h5
`define VTP_CODE_HRAMP_LO 4'h6
`define VTP_CODE_HRAMP_HI 4'h9
`define VTP_CODE_VRAMP_LO 4'ha
`define VTP_CODE_VRAMP_HI 4'hd
`define VTP_CODE_CUSTOM 4'he

// Ramp and bar steps per active region
`define VTP_RAMP_STEPS 32'd256
`define VTP_BAR_COUNT 32'd8

`endif

// File: src/vtp_pkg.sv
package vtp_pkg;

    // Which source drives the pixel
    typedef enum logic [1:0]
    {
        VTP_MODE_OFF,
        VTP_MODE_FIXED,
        VTP_MODE_BARS,
        VTP_MODE_COMPLIANCE
    } vtp_mode_t;

    // One pixel colour
    typedef struct packed
    {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vtp_rgb_t;

endpackage

// File: src/vtp_pix_if.sv
`timescale 1ns/1ns
`default_nettype none

// Carries per-pixel selection state to the colour stage
interface vtp_pix_if;
    import vtp_pkg::*;
    vtp_mode_t mode; // Active source
    logic [3:0] code; // Effective selection code
    logic invert; // Inverted colour variant
    vtp_rgb_t custom; // Custom colour levels
    logic [7:0] hlevel; // Horizontal ramp level
    logic [7:0] vlevel; // Vertical ramp level
    logic [2:0] bar; // Colour bar index
    logic check; // Compliance checker phase

    modport src (output mode, code, invert, custom, hlevel, vlevel, bar,
        check);
    modport dst (input mode, code, invert, custom, hlevel, vlevel, bar,
        check);
endinterface

`default_nettype wire

// File: src/vtp_colour.sv
`timescale 1ns/1ns
`default_nettype none
`include "vtp_params.svh"

module vtp_colour
(
    input wire logic clk_sys,
    input wire logic reset_n,
    vtp_pix_if.dst pix,
    output vtp_pkg::vtp_rgb_t rgb_r
);
    import vtp_pkg::*;

    vtp_rgb_t base; // Non-inverted colour
    logic [7:0] lvl; // Ramp level in use

    // Non-inverted colour for the chosen source
    always_comb
    begin
        base = '0;
        lvl = (pix.code >= `VTP_CODE_VRAMP_LO) ? pix.vlevel : pix.hlevel;
        case (pix.mode)
            VTP_MODE_COMPLIANCE:
            begin
                // Alternating full swing pixels
                base = pix.check ? {8'hff, 8'hff, 8'hff} : '0;
            end
            VTP_MODE_BARS:
            begin
                // White, yellow, cyan, green, magenta, red, blue, black
                base.red = (pix.bar == 3'h0 || pix.bar == 3'h1 ||
                    pix.bar == 3'h4 || pix.bar == 3'h5) ? 8'hff : 8'h00;
                base.green = (pix.bar <= 3'h3) ? 8'hff : 8'h00;
                base.blue = (pix.bar == 3'h0 || pix.bar == 3'h2 ||
                    pix.bar == 3'h4 || pix.bar == 3'h6) ? 8'hff : 8'h00;
            end
            VTP_MODE_FIXED:
            begin
                case (pix.code)
                    4'h1: base = {8'hff, 8'hff, 8'hff};
                    4'h2: base = '0;
                    4'h3: base = {8'hff, 8'h00, 8'h00};
                    4'h4: base = {8'h00, 8'hff, 8'h00};
                    4'h5: base = {8'h00, 8'h00, 8'hff};
                    // Ramps: grey, red, green, blue
                    4'h6, 4'ha: base = {lvl, lvl, lvl};
                    4'h7, 4'hb: base = {lvl, 8'h00, 8'h00};
                    4'h8, 4'hc: base = {8'h00, lvl, 8'h00};
                    4'h9, 4'hd: base = {8'h00, 8'h00, lvl};
                    `VTP_CODE_CUSTOM: base = pix.custom;
                    default: base = '0; // Reserved codes give black
                endcase
            end
            default: base = '0;
        endcase
    end

    // Output register with optional inversion
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rgb_r <= '0;
        else if (pix.mode == VTP_MODE_OFF)
            rgb_r <= '0;
        else if (pix.invert)
            rgb_r <= ~base;
        else
            rgb_r <= base;
    end

endmodule // vtp_colour

`default_nettype wire

// File: src/vtp_select.sv
`timescale 1ns/1ns
`default_nettype none
`include "vtp_params.svh"

module vtp_select
#(
    parameter int H_ACTIVE = 1920, // Active pixels per line, at least 256
    parameter int V_ACTIVE = 1080 // Active lines per frame, at least 256
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic vid_de,
    input wire logic vid_vs,
    input wire logic auto_scroll_on,
    output vtp_pkg::vtp_rgb_t pix_rgb,
    output logic pix_de,
    output logic pat_active
);
    import vtp_pkg::*;

    localparam logic [15:0] H_ACT = 16'(H_ACTIVE); // Line width
    localparam logic [15:0] V_ACT = 16'(V_ACTIVE); // Frame height
    localparam logic [15:0] RAMP_STEP = 16'(`VTP_RAMP_STEPS);
    localparam logic [15:0] BAR_STEP = 16'(`VTP_BAR_COUNT);

    logic [3:0] fixed_pattern_choice_r; // Fixed selection field
    logic compliance_pattern_force_r; // Compliance override
    logic colour_bars_force_r; // Colour bars override
    logic pattern_gen_on_r; // Generator enable
    logic colour_invert_r; // Inverted variant
    logic [7:0] custom_red_level_r; // Custom red
    logic [7:0] custom_green_level_r; // Custom green
    logic [7:0] custom_blue_level_r; // Custom blue
    logic [3:0] scroll_code_r; // Auto-scroll pattern code
    logic vid_de_r; // Previous data enable
    logic vid_vs_r; // Previous vertical sync
    logic [15:0] hacc_r; // Horizontal ramp remainder
    logic [15:0] hacc_nxt;
    logic [7:0] hlevel_r; // Horizontal ramp level
    logic [15:0] bacc_r; // Bar remainder
    logic [15:0] bacc_nxt;
    logic [2:0] bar_r; // Bar index
    logic [15:0] vacc_r; // Vertical ramp remainder
    logic [15:0] vacc_nxt;
    logic [7:0] vlevel_r; // Vertical ramp level
    logic check_r; // Compliance pixel phase
    logic line_end; // Falling edge of data enable
    logic frame_start; // Rising edge of vertical sync
    vtp_mode_t mode; // Source chosen this cycle
    logic [3:0] code; // Effective selection code

    vtp_pix_if pix ();

    assign line_end = vid_de_r && !vid_de;
    assign frame_start = vid_vs && !vid_vs_r;

    // Register writes on the control bus
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fixed_pattern_choice_r <= `VTP_CHOICE_RST;
            compliance_pattern_force_r <= 1'b0;
            colour_bars_force_r <= 1'b0;
            pattern_gen_on_r <= 1'b0;
            colour_invert_r <= 1'b0;
            custom_red_level_r <= `VTP_CUSTOM_RST;
            custom_green_level_r <= `VTP_CUSTOM_RST;
            custom_blue_level_r <= `VTP_CUSTOM_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `VTP_FIXED_PATTERN_CONTROL_OFS:
                begin
                    fixed_pattern_choice_r <=
                        reg_wdata[`VTP_CHOICE_MSB:`VTP_CHOICE_LSB];
                    compliance_pattern_force_r <=
                        reg_wdata[`VTP_COMPLIANCE_BIT];
                    colour_bars_force_r <= reg_wdata[`VTP_BARS_BIT];
                    pattern_gen_on_r <= reg_wdata[`VTP_ENABLE_BIT];
                end
                `VTP_PATTERN_CONFIG_OFS:
                    colour_invert_r <= reg_wdata[`VTP_INVERT_BIT];
                `VTP_CUSTOM_RED_OFS: custom_red_level_r <= reg_wdata;
                `VTP_CUSTOM_GREEN_OFS: custom_green_level_r <= reg_wdata;
                `VTP_CUSTOM_BLUE_OFS: custom_blue_level_r <= reg_wdata;
                default: ; // Unmapped writes are dropped
            endcase
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            reg_rdata <= 8'h00;
            case (reg_addr)
                `VTP_FIXED_PATTERN_CONTROL_OFS:
                begin
                    reg_rdata[`VTP_CHOICE_MSB:`VTP_CHOICE_LSB] <=
                        fixed_pattern_choice_r;
                    reg_rdata[`VTP_COMPLIANCE_BIT] <=
                        compliance_pattern_force_r;
                    reg_rdata[`VTP_BARS_BIT] <= colour_bars_force_r;
                    reg_rdata[`VTP_ENABLE_BIT] <= pattern_gen_on_r;
                end
                `VTP_PATTERN_CONFIG_OFS:
                    reg_rdata[`VTP_INVERT_BIT] <= colour_invert_r;
                `VTP_CUSTOM_RED_OFS: reg_rdata <= custom_red_level_r;
                `VTP_CUSTOM_GREEN_OFS: reg_rdata <= custom_green_level_r;
                `VTP_CUSTOM_BLUE_OFS: reg_rdata <= custom_blue_level_r;
                `VTP_STATUS_OFS:
                begin
                    // Live state of the generator
                    reg_rdata[`VTP_STAT_ACTIVE_BIT] <= pat_active;
                    reg_rdata[`VTP_STAT_CODE_MSB:`VTP_STAT_CODE_LSB] <=
                        code;
                end
                default: reg_rdata <= 8'h00; // Unmapped reads as zero
            endcase
        end
    end

    // Edge history of the video timing inputs
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vid_de_r <= 1'b0;
            vid_vs_r <= 1'b0;
        end
        else
        begin
            vid_de_r <= vid_de;
            vid_vs_r <= vid_vs;
        end
    end

    // Next remainders of the even-step spreaders
    always_comb
    begin
        hacc_nxt = hacc_r + RAMP_STEP;
        bacc_nxt = bacc_r + BAR_STEP;
        vacc_nxt = vacc_r + RAMP_STEP;
    end

    // Horizontal ramp level and bar index across the active line
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hacc_r <= 16'h0000;
            hlevel_r <= 8'h00;
            bacc_r <= 16'h0000;
            bar_r <= 3'h0;
        end
        else if (!vid_de)
        begin
            hacc_r <= 16'h0000;
            hlevel_r <= 8'h00;
            bacc_r <= 16'h0000;
            bar_r <= 3'h0;
        end
        else
        begin
            // Level = pixel * 256 / width, stepped without a divider
            if (hacc_nxt >= H_ACT)
            begin
                hacc_r <= hacc_nxt - H_ACT;
                if (hlevel_r != 8'hff)
                    hlevel_r <= hlevel_r + 8'h01;
            end
            else
                hacc_r <= hacc_nxt;
            if (bacc_nxt >= H_ACT)
            begin
                bacc_r <= bacc_nxt - H_ACT;
                if (bar_r != 3'h7)
                    bar_r <= bar_r + 3'h1;
            end
            else
                bacc_r <= bacc_nxt;
        end
    end

    // Vertical ramp level, stepped at each line end
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vacc_r <= 16'h0000;
            vlevel_r <= 8'h00;
        end
        else if (frame_start)
        begin
            vacc_r <= 16'h0000;
            vlevel_r <= 8'h00;
        end
        else if (line_end)
        begin
            if (vacc_nxt >= V_ACT)
            begin
                vacc_r <= vacc_nxt - V_ACT;
                if (vlevel_r != 8'hff)
                    vlevel_r <= vlevel_r + 8'h01;
            end
            else
                vacc_r <= vacc_nxt;
        end
    end

    // Compliance phase toggles every active pixel
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            check_r <= 1'b0;
        else if (frame_start)
            check_r <= 1'b0;
        else if (vid_de)
            check_r <= !check_r;
    end

    // Auto-scroll walks codes 1 to 14, one per frame
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            scroll_code_r <= `VTP_CODE_SOLID_LO;
        else if (frame_start && auto_scroll_on)
        begin
            if (scroll_code_r >= `VTP_CODE_CUSTOM)
                scroll_code_r <= `VTP_CODE_SOLID_LO;
            else
                scroll_code_r <= scroll_code_r + 4'h1;
        end
    end

    // Source priority: off, compliance, bars, scroll, fixed choice
    always_comb
    begin
        code = fixed_pattern_choice_r;
        if (auto_scroll_on)
            code = scroll_code_r;
        if (!pattern_gen_on_r)
            mode = VTP_MODE_OFF;
        else if (compliance_pattern_force_r)
            mode = VTP_MODE_COMPLIANCE;
        else if (colour_bars_force_r)
            mode = VTP_MODE_BARS;
        else
            mode = VTP_MODE_FIXED;
    end

    // Hand the selection to the colour stage
    assign pix.mode = mode;
    assign pix.code = code;
    assign pix.invert = colour_invert_r;
    assign pix.custom = {custom_red_level_r, custom_green_level_r,
        custom_blue_level_r};
    assign pix.hlevel = hlevel_r;
    assign pix.vlevel = vlevel_r;
    assign pix.bar = bar_r;
    assign pix.check = check_r;

    vtp_colour u_colour
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pix(pix),
        .rgb_r(pix_rgb)
    );

    // Data enable and activity, aligned with the colour register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pix_de <= 1'b0;
            pat_active <= 1'b0;
        end
        else
        begin
            pix_de <= vid_de;
            pat_active <= pattern_gen_on_r;
        end
    end

endmodule // vtp_select

`default_nettype wire

// File: dv/vtp_select_chk.sv
`timescale 1ns/1ns
`default_nettype none

// Watches selector ports against a shadow of its control bits
module vtp_select_chk
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic vid_de,
    input wire logic vid_vs,
    input wire logic auto_scroll_on,
    input wire vtp_pkg::vtp_rgb_t pix_rgb,
    input wire logic pix_de,
    input wire logic pat_active
);
    import vtp_pkg::*;
    logic [7:0] ctl_r; // Shadow pattern control
    logic inv_r; // Shadow invert bit
    logic fix_go; // Fixed choice drives this pixel

    // Track software writes to the control registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_r <= 8'h10;
            inv_r <= 1'b0;
        end
        else if (reg_wr && reg_addr == 8'h64)
            ctl_r <= reg_wdata;
        else if (reg_wr && reg_addr == 8'h65)
            inv_r <= reg_wdata[1];
    end

    // Enabled, no override, no scrolling
    assign fix_go = vid_de && ctl_r[0] && ctl_r[3:2] == 2'b00
        && !auto_scroll_on;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    AST_OFF_BLACK: assert property (!pat_active
        |-> pix_rgb == 24'h0)
        else $error("pixel not black while generator off");
    AST_ENABLE_TRACK: assert property (reg_wr && reg_addr == 8'h64
        |=> ##1 pat_active == $past(reg_wdata[0], 2))
        else $error("active flag does not follow enable bit");
    AST_CTL_READBACK: assert property (reg_rd && reg_addr == 8'h64
        |=> reg_rdata == ($past(ctl_r) & 8'hfd))
        else $error("control register read back wrong");
    AST_INV_READBACK: assert property (reg_rd && reg_addr == 8'h65
        |=> reg_rdata == {6'h00, $past(inv_r), 1'b0})
        else $error("invert register read back wrong");
    AST_WHITE_SOLID: assert property (fix_go && ctl_r[7:4] == 4'h1
        |=> pix_rgb == {24{!$past(inv_r)}})
        else $error("code one colour wrong");
    AST_BLACK_SOLID: assert property (fix_go && ctl_r[7:4] == 4'h2
        |=> pix_rgb == {24{$past(inv_r)}})
        else $error("code two colour wrong");
    AST_HRAMP_START: assert property (fix_go && ctl_r[7:4] == 4'h6
        && !inv_r && !$past(vid_de) |=> pix_rgb == 24'h0)
        else $error("horizontal ramp does not start black");
    AST_COMPLIANCE: assert property (vid_de && ctl_r[0] && ctl_r[3]
        |=> pix_rgb inside {24'h0, 24'hffffff})
        else $error("compliance pixel not black or white");
    AST_BARS_FIRST: assert property (vid_de && ctl_r[3:2] == 2'b01
        && ctl_r[0] && !inv_r && !$past(vid_de) |=> pix_rgb == 24'hffffff)
        else $error("first colour bar not white");
    AST_RDATA_HOLD: assert property (!reg_rd
        |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule // vtp_select_chk

bind vtp_select vtp_select_chk chk_i
(
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vid_de(vid_de), .vid_vs(vid_vs),
    .auto_scroll_on(auto_scroll_on), .pix_rgb(pix_rgb), .pix_de(pix_de),
    .pat_active(pat_active)
);

`default_nettype wire

// File: dv/vtp_select_tb.sv
`timescale 1ns/1ns
`default_nettype none

module vtp_select_tb;
    import vtp_pkg::*;
    logic clk_sys = 1'b0; // System clock
    logic reset_n = 1'b0; // Held low at start
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic vid_de = 1'b0;
    logic vid_vs = 1'b0;
    logic auto_scroll_on = 1'b0;
    vtp_rgb_t pix_rgb;
    logic pix_de;
    logic pat_active;
    int fails = 0; // Mismatch count
    int n_compared = 0; // Comparison count
    int cyc = 0; // Cycles for the timeout
    int code = 1; // Expected pattern code
    bit bars = 1'b0; // Expected overrides and modes
    bit comp = 1'b0;
    bit en = 1'b0;
    bit inv = 1'b0;
    logic [23:0] cust = 24'h123456; // Custom colour written
    logic [23:0] sol_tab [6] = '{24'h0, 24'hffffff, 24'h0, 24'hff0000,
        24'h00ff00, 24'h0000ff};
    logic [23:0] ramp_mask [4] = '{24'hffffff, 24'hff0000, 24'h00ff00,
        24'h0000ff};
    logic [23:0] bar_tab [8] = '{24'hffffff, 24'hffff00, 24'h00ffff,
        24'h00ff00, 24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    vtp_select #(.H_ACTIVE(256), .V_ACTIVE(256)) dut
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vid_de(vid_de), .vid_vs(vid_vs),
        .auto_scroll_on(auto_scroll_on), .pix_rgb(pix_rgb),
        .pix_de(pix_de), .pat_active(pat_active)
    );

    // Verdict and end of run
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(logic [23:0] got, logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // One-cycle read strobe, data one edge later
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk({16'h0, reg_rdata}, {16'h0, e});
    endtask

    // Program both control registers and the expectation
    task automatic cfg(int c, bit b, bit p, bit e, bit i);
        code = c;
        bars = b;
        comp = p;
        en = e;
        inv = i;
        wr(8'h64, {4'(c), p, b, 1'b0, e});
        wr(8'h65, {6'h00, i, 1'b0});
    endtask

    // Frame start pulse
    task automatic vs_pulse();
        @(negedge clk_sys);
        vid_vs = 1'b1;
        @(negedge clk_sys);
        vid_vs = 1'b0;
    endtask

    // Expected pixel at column x, line y
    function automatic logic [23:0] exp_pix(int x, int y);
        logic [7:0] l;
        logic [23:0] c;
        l = (code < 10) ? 8'(x) : 8'(y);
        if (code >= 6 && code <= 13)
            c = {l, l, l} & ramp_mask[(code - 6) % 4];
        else if (code == 14)
            c = cust;
        else
            c = sol_tab[code];
        if (bars)
            c = bar_tab[x / 32];
        if (comp)
            c = (x % 2) ? 24'hffffff : 24'h0;
        if (inv)
            c = ~c;
        if (!en)
            c = 24'h0;
        return c;
    endfunction

    // Drive one active line and check every pixel a cycle later
    task automatic run_line(int n, int y);
        for (int x = 0; x <= n; x++)
        begin
            @(negedge clk_sys);
            if (x > 0)
            begin
                chk(pix_rgb, exp_pix(x - 1, y));
                chk({23'h0, pix_de}, 24'h000001);
                chk({23'h0, pat_active}, {23'h0, en});
            end
            vid_de = (x < n);
        end
    endtask

    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            fails = fails + 1;
            finish_test();
        end
    end

    // Main sequence
    initial
    begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        rd(8'h64, 8'h10);
        rd(8'h65, 8'h00);
        rd(8'h66, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h64, 8'hff);
        rd(8'h64, 8'hfd);
        rd(8'h69, 8'hf1);
        wr(8'h65, 8'hff);
        rd(8'h65, 8'h02);
        wr(8'h66, 8'h12);
        wr(8'h67, 8'h34);
        wr(8'h68, 8'h56);
        rd(8'h67, 8'h34);
        $display("registers done");
        for (int i = 0; i < 2; i++)
            for (int c = 1; c < 15; c++)
            begin
                cfg(c, 1'b0, 1'b0, 1'b1, bit'(i));
                vs_pulse();
                for (int y = 0; y < 4; y++)
                    run_line(256, y);
            end
        $display("fixed patterns done");
        cfg(3, 1'b0, 1'b0, 1'b0, 1'b1);
        run_line(8, 0);
        cfg(3, 1'b1, 1'b0, 1'b1, 1'b0);
        run_line(256, 0);
        cfg(3, 1'b1, 1'b0, 1'b1, 1'b1);
        run_line(256, 0);
        cfg(3, 1'b1, 1'b1, 1'b1, 1'b0);
        vs_pulse();
        run_line(16, 0);
        $display("overrides done");
        auto_scroll_on = 1'b1;
        cfg(14, 1'b0, 1'b0, 1'b1, 1'b0);
        code = 1;
        run_line(8, 0);
        vs_pulse();
        code = 2;
        run_line(8, 0);
        rd(8'h69, 8'h21);
        auto_scroll_on = 1'b0;
        $display("auto scroll done");
        finish_test();
    end
endmodule // vtp_select_tb

`default_nettype wire
